// ---- test/ppr_checker.sv ----
// Concurrent checks on the ports of the PID regulator.
`timescale 1ns/1ns
module ppr_checker #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic               clk,
   input wire logic               nrst,
   input wire ppr_pkg::ppr_bus_t  bus,
   input wire logic [31:0]        rdata,
   input wire logic signed [16:0] freqCmd,
   input wire logic [15:0]        setpointDisplay,
   input wire logic [15:0]        feedbackDisplay
);
   import ppr_pkg::*;
   logic [5:0]  idx;
   logic [15:0] wd16;
   int          sinceChg;
   assign idx  = bus.addr[7:2];
   assign wd16 = bus.wdata[15:0];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Counts cycles since any control output last moved.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sinceChg <= 0;
      end else if ($changed(freqCmd) || $changed(setpointDisplay)
                   || $changed(feedbackDisplay)) begin
         sinceChg <= 0;
      end else begin
         sinceChg <= sinceChg + 1;
      end
   end
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_unmapped_zero: assert property (bus.rd && (idx inside {[25:31]}
      || idx > 6'h22) |=> rdata == 32'h0)
      else $error("unmapped read returned data");
   a_upper_zero: assert property (bus.rd && idx != 6'h22
      |=> rdata[31:16] == 16'h0)
      else $error("upper half of read data not zero");
   a_freq_read: assert property (
      bus.rd && idx == 6'h22 |=> rdata[16:0] == $past(freqCmd)
      && rdata[31:17] == {15{rdata[16]}})
      else $error("frequency read mismatch");
   a_disp_read: assert property (
      bus.rd && idx == 6'h20 |=> rdata[15:0] == $past(setpointDisplay))
      else $error("setpoint display read mismatch");
   a_write_readback: assert property (
      bus.wr && (idx == 6'h01 || idx inside {[4:16]}) ##1
      bus.rd && $stable(bus.addr) |=> rdata[15:0] == $past(wd16, 2))
      else $error("register readback mismatch");
   a_tick_spacing: assert property (
      $changed(freqCmd) || $changed(setpointDisplay)
      || $changed(feedbackDisplay) |-> sinceChg >= TICK_CYCLES - 1)
      else $error("outputs moved between control ticks");
   a_reset_zero: assert property ($rose(nrst) |-> freqCmd == 17'sh0
      && setpointDisplay == 16'h0 && feedbackDisplay == 16'h0
      && rdata == 32'h0)
      else $error("outputs not zero after reset");
endmodule

// ---- test/ppr_src_model.sv ----
// Analog, pulse and communication sources feeding the regulator.
`timescale 1ns/1ns
module ppr_src_model (
   input wire logic              clk,
   output ppr_pkg::ppr_src_t     src,
   output logic signed [16:0]    mainFreq
);
   import ppr_pkg::*;
   // Distinct percentages so every selector code except FB_MAX and FB_MIN is told apart.
   always_ff @(posedge clk) begin
      src      <= '{10'h258, 10'h0FA, 10'h096, 10'h2BC, 10'h140, 10'h370};
      mainFreq <= 17'sh00FA0;
   end
endmodule

// ---- test/tb_top.sv ----
// Self-checking testbench of the PID regulator.
`timescale 1ns/1ns
module tb_top;
   import ppr_pkg::*;
   localparam int      TICK = 10;
   logic               clk;
   logic               nrst;
   ppr_bus_t           bus;
   logic [31:0]        rdata;
   ppr_src_t           src;
   logic signed [16:0] mainFreq;
   logic               dirInvertPin;
   logic               gainSelPin;
   logic signed [16:0] freqCmd;
   logic [15:0]        setpointDisplay;
   logic [15:0]        feedbackDisplay;
   int                 n_mismatch;
   int                 n_checks;
   logic [31:0]        v;
   logic [31:0]        f0;
   int                 rIx[10] = '{1, 4, 5, 6, 8, 9, 10, 11, 12, 13};
   logic [15:0]        rVal[10] = '{16'h01F4, 16'h03E8, 16'h00C8,
      16'h00C8, 16'h0000, 16'h0000, 16'h000A, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0]        spExp[7] = '{16'h01F4, 16'h0258, 16'h00FA,
      16'h0096, 16'h02BC, 16'h0140, 16'h0370};
   logic [15:0]        fbExp[9] = '{16'h0258, 16'h00FA, 16'h0096, 16'h015E,
      16'h02BC, 16'h0140, 16'h0352, 16'h0258, 16'h00FA};

   ppr_regulator #(.TICK_CYCLES(TICK)) u_ppr_regulator (.clk(clk),
      .nrst(nrst), .bus(bus), .rdata(rdata), .src(src),
      .mainFreq(mainFreq), .dirInvertPin(dirInvertPin),
      .gainSelPin(gainSelPin), .freqCmd(freqCmd),
      .setpointDisplay(setpointDisplay), .feedbackDisplay(feedbackDisplay));
   ppr_src_model u_ppr_src_model (.clk(clk), .src(src), .mainFreq(mainFreq));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdReg(input int ix, output logic [31:0] d);
      @(posedge clk);
      bus.addr <= 8'(ix * 4);
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic setReg(input int ix, input logic [15:0] d);
      @(posedge clk);
      bus <= '{8'(ix * 4), {16'h0, d}, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 check(rdata, {16'h0, d});
   endtask
   task automatic waitT(input int n);
      repeat (n * TICK) @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
   initial begin
      nrst = 1'b0;
      bus = '0;
      dirInvertPin = 1'b0;
      gainSelPin = 1'b0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rdReg(rIx[i], v);
         check(v, {16'h0, rVal[i]});
      end
      rdReg(30, v);
      check(v, 32'h0);
      $display("test defaults done");
      for (int c = 0; c < 7; c++) begin
         setReg(0, 16'(c));
         waitT(3);
         check({16'h0, setpointDisplay}, {16'h0, spExp[c]});
      end
      setReg(4, 16'h07D0);
      waitT(3);
      rdReg(32, v);
      check(v, 32'h000006E0);
      setReg(4, 16'h03E8);
      for (int c = 0; c < 9; c++) begin
         setReg(2, 16'(c));
         waitT(3);
         check({16'h0, feedbackDisplay}, {16'h0, fbExp[c]});
      end
      $display("test selectors done");
      setReg(0, 16'h0000);
      setReg(1, 16'h03E8);
      setReg(5, 16'h2710);
      setReg(21, 16'h0BB8);
      setReg(22, 16'h0064);
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000BB8);
      setReg(3, 16'h0001);
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000064);
      setReg(8, 16'h0320);
      waitT(4);
      rdReg(34, v);
      check(v, 32'hFFFFFCE0);
      setReg(20, 16'h0001);
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000064);
      @(posedge clk);
      dirInvertPin <= 1'b1;
      waitT(4);
      rdReg(34, f0);
      check(f0, 32'h00000BB8);
      $display("test limits done");
      setReg(9, 16'h03E8);
      setReg(1, 16'h0000);
      waitT(4);
      rdReg(34, v);
      check(v, f0);
      setReg(9, 16'h0000);
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000064);
      $display("test deadband done");
      setReg(11, 16'h0001);
      setReg(1, 16'h03E8);
      waitT(3);
      check({31'h0, setpointDisplay > 16'h0 && setpointDisplay < 16'h03E8},
            32'h1);
      waitT(14);
      check({16'h0, setpointDisplay}, 32'h000003E8);
      setReg(12, 16'h0001);
      setReg(2, 16'h0004);
      waitT(2);
      check({31'h0, feedbackDisplay > 16'h00FA && feedbackDisplay < 16'h02BC},
            32'h1);
      setReg(23, 16'h0000);
      setReg(21, 16'h1388);
      setReg(24, 16'h0001);
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000FA0);
      setReg(24, 16'h0000);
      setReg(12, 16'h0000);
      setReg(6, 16'hFFFF);
      setReg(15, 16'hFFFF);
      setReg(5, 16'h0000);
      setReg(14, 16'h0064);
      setReg(17, 16'h0001);
      setReg(23, 16'h1388);
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000064);
      @(posedge clk);
      gainSelPin <= 1'b1;
      waitT(4);
      rdReg(34, v);
      check(v, 32'h00000096);
      setReg(14, 16'h0000);
      setReg(16, 16'h03E8);
      setReg(10, 16'h2710);
      setReg(12, 16'h0001);
      waitT(2);
      setReg(2, 16'h0002);
      waitT(3);
      rdReg(34, v);
      check({31'h0, v > 32'h64 && v < 32'h1388}, 32'h1);
      setReg(10, 16'h000A);
      setReg(2, 16'h0004);
      waitT(40);
      setReg(2, 16'h0002);
      waitT(3);
      rdReg(34, v);
      check({31'h0, v >= 32'h64 && v <= 32'h69}, 32'h1);
      $display("test ramp and filter done");
      summarize();
   end
endmodule

bind ppr_regulator ppr_checker #(.TICK_CYCLES(TICK_CYCLES)) u_ppr_checker (
   .clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .freqCmd(freqCmd),
   .setpointDisplay(setpointDisplay), .feedbackDisplay(feedbackDisplay));

// ---- verilog/ppr_pkg.sv ----
// Types shared by the PID regulator and its surroundings.
package ppr_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ppr_bus_t;

   typedef struct packed {
      logic [9:0] analogInOne;
      logic [9:0] analogInTwo;
      logic [9:0] analogInThree;
      logic [9:0] pulseIn;
      logic [9:0] commIn;
      logic [9:0] multiSegIn;
   } ppr_src_t;

   typedef enum logic [2:0] {
      SP_FIXED, SP_AIN1, SP_AIN2, SP_AIN3, SP_PULSE, SP_COMM, SP_MSEG
   } ppr_spsel_t;

   typedef enum logic [3:0] {
      FB_AIN1, FB_AIN2, FB_AIN3, FB_DIFF, FB_PULSE, FB_COMM, FB_SUM,
      FB_MAX, FB_MIN
   } ppr_fbsel_t;

endpackage

// ---- verilog/ppr_regs.svh ----
// Register offsets, reset values and timing counts of the PID regulator.
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH

`define PPR_CLK_MHZ       50
`define PPR_TICK_US       1000
`define PPR_TICK_CYC      (`PPR_TICK_US * `PPR_CLK_MHZ)
`define PPR_TICKS_PER_CS  10
`define PPR_FULL_PCT      1000
`define PPR_FRAC          8

`define PPR_NCFG          25
`define PPR_IX_SETSEL     0
`define PPR_IX_FIXSP      1
`define PPR_IX_FBSEL      2
`define PPR_IX_DIR        3
`define PPR_IX_DISPFS     4
`define PPR_IX_KP1        5
`define PPR_IX_TI1        6
`define PPR_IX_TD1        7
`define PPR_IX_REVCUT     8
`define PPR_IX_DEADBAND   9
`define PPR_IX_DCLAMP     10
`define PPR_IX_RAMPT      11
`define PPR_IX_FBFILT     12
`define PPR_IX_OUTFILT    13
`define PPR_IX_KP2        14
`define PPR_IX_TI2        15
`define PPR_IX_TD2        16
`define PPR_IX_SWMODE     17
`define PPR_IX_SWDEV1     18
`define PPR_IX_SWDEV2     19
`define PPR_IX_REVPROH    20
`define PPR_IX_UPPER      21
`define PPR_IX_LOWER      22
`define PPR_IX_MAXF       23
`define PPR_IX_COMBINE    24
`define PPR_IX_SPDISP     32
`define PPR_IX_FBDISP     33
`define PPR_IX_FREQCMD    34

`define PPR_RST_FIXSP     16'h01F4
`define PPR_RST_DISPFS    16'h03E8
`define PPR_RST_KP        16'h00C8
`define PPR_RST_TI        16'h00C8
`define PPR_RST_DCLAMP    16'h000A
`define PPR_RST_SWDEV1    16'h00C8
`define PPR_RST_SWDEV2    16'h0320
`define PPR_RST_FREQ      16'h1388

`endif

// ---- verilog/ppr_regulator.sv ----
// Process PID regulator with setpoint ramp, filters and frequency limits.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "ppr_regs.svh"

module ppr_regulator #(
   parameter int TICK_CYCLES = `PPR_TICK_CYC
) (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire ppr_pkg::ppr_bus_t   bus,
   output logic [31:0]              rdata,
   input  wire ppr_pkg::ppr_src_t   src,
   input  wire logic signed [16:0]  mainFreq,
   input  wire logic                dirInvertPin,
   input  wire logic                gainSelPin,
   output logic signed [16:0]       freqCmd,
   output logic [15:0]              setpointDisplay,
   output logic [15:0]              feedbackDisplay
);
   import ppr_pkg::*;

   localparam int FR = `PPR_FRAC;
   localparam logic [15:0] RST_TBL [`PPR_NCFG] = '{
      16'h0000, `PPR_RST_FIXSP, 16'h0000, 16'h0000, `PPR_RST_DISPFS,
      `PPR_RST_KP, `PPR_RST_TI, 16'h0000, 16'h0000, 16'h0000,
      `PPR_RST_DCLAMP, 16'h0000, 16'h0000, 16'h0000, `PPR_RST_KP,
      `PPR_RST_TI, 16'h0000, 16'h0000, `PPR_RST_SWDEV1,
      `PPR_RST_SWDEV2, 16'h0000, `PPR_RST_FREQ, 16'h0000,
      `PPR_RST_FREQ, 16'h0000};

   logic [15:0]         cfgFf [`PPR_NCFG];
   logic [31:0]         rdataFf;
   logic [31:0]         nxt_rdata;
   logic [15:0]         tickCntFf;
   logic                tick;
   logic                tickDlyFf;
   logic [1:0]          dirSyncFf;
   logic [1:0]          gainSyncFf;
   logic signed [47:0]  spAccFf;
   logic signed [47:0]  fbAccFf;
   logic signed [47:0]  fbPrevFf;
   logic signed [47:0]  iAccFf;
   logic signed [47:0]  pidFf;
   logic signed [47:0]  outAccFf;
   logic signed [47:0]  nxt_spAcc;
   logic signed [47:0]  nxt_fbAcc;
   logic signed [47:0]  nxt_iAcc;
   logic signed [47:0]  nxt_pid;
   logic signed [47:0]  nxt_outAcc;
   logic [9:0]          spTarget;
   logic [9:0]          fbRaw;
   logic [15:0]         kpSel;
   logic [15:0]         tiSel;
   logic [15:0]         tdSel;

   wire logic [5:0]  regIdx = bus.addr[7:2];
   wire logic signed [47:0] fMax = {32'h0, cfgFf[`PPR_IX_MAXF]};
   wire logic signed [47:0] spEff = spAccFf >>> FR;
   wire logic signed [47:0] fbNow = fbAccFf >>> FR;
   wire logic signed [47:0] errRaw = spEff - fbNow;
   wire logic dirRev = cfgFf[`PPR_IX_DIR][0] ^ dirSyncFf[1];
   wire logic signed [47:0] err = dirRev ? -errRaw : errRaw;
   wire logic signed [47:0] absErr = errRaw < 0 ? -errRaw : errRaw;
   wire logic holdPid = absErr < {32'h0, cfgFf[`PPR_IX_DEADBAND]};

   // Register bank: every entry is written by the same decode.
   genvar gi;
   generate
      for (gi = 0; gi < `PPR_NCFG; gi++) begin : gCfg
         always_ff @(posedge clk) begin
            if (!nrst) begin
               cfgFf[gi] <= RST_TBL[gi];
            end else if (bus.wr && regIdx == 6'(gi)) begin
               cfgFf[gi] <= bus.wdata[15:0];
            end
         end
      end
   endgenerate

   always_comb begin
      nxt_rdata = 32'h0;
      if (bus.rd) begin
         if (regIdx < 6'(`PPR_NCFG)) begin
            nxt_rdata = {16'h0, cfgFf[regIdx[4:0]]};
         end else if (regIdx == 6'(`PPR_IX_SPDISP)) begin
            nxt_rdata = {16'h0, setpointDisplay};
         end else if (regIdx == 6'(`PPR_IX_FBDISP)) begin
            nxt_rdata = {16'h0, feedbackDisplay};
         end else if (regIdx == 6'(`PPR_IX_FREQCMD)) begin
            nxt_rdata = {{15{freqCmd[16]}}, freqCmd};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdataFf <= 32'h0;
      end else begin
         rdataFf <= nxt_rdata;
      end
   end
   assign rdata = rdataFf;

   // Control tick and digital input synchronisers.
   assign tick = tickCntFf == 16'(TICK_CYCLES - 1);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tickCntFf  <= 16'h0;
         tickDlyFf  <= 1'b0;
         dirSyncFf  <= 2'h0;
         gainSyncFf <= 2'h0;
      end else begin
         tickCntFf  <= tick ? 16'h0 : tickCntFf + 16'h1;
         tickDlyFf  <= tick;
         dirSyncFf  <= {dirSyncFf[0], dirInvertPin};
         gainSyncFf <= {gainSyncFf[0], gainSelPin};
      end
   end

   // Source selection.
   always_comb begin
      unique case (ppr_spsel_t'(cfgFf[`PPR_IX_SETSEL][2:0]))
         SP_FIXED: spTarget = cfgFf[`PPR_IX_FIXSP][9:0];
         SP_AIN1:  spTarget = src.analogInOne;
         SP_AIN2:  spTarget = src.analogInTwo;
         SP_AIN3:  spTarget = src.analogInThree;
         SP_PULSE: spTarget = src.pulseIn;
         SP_COMM:  spTarget = src.commIn;
         SP_MSEG:  spTarget = src.multiSegIn;
         default:  spTarget = cfgFf[`PPR_IX_FIXSP][9:0];
      endcase
   end

   wire logic [10:0] aSum = {1'b0, src.analogInOne} + {1'b0, src.analogInTwo};
   wire logic aOneBig = src.analogInOne > src.analogInTwo;
   always_comb begin
      unique case (ppr_fbsel_t'(cfgFf[`PPR_IX_FBSEL][3:0]))
         FB_AIN1:  fbRaw = src.analogInOne;
         FB_AIN2:  fbRaw = src.analogInTwo;
         FB_AIN3:  fbRaw = src.analogInThree;
         FB_DIFF:  fbRaw = aOneBig ? src.analogInOne - src.analogInTwo
                                   : 10'h0;
         FB_PULSE: fbRaw = src.pulseIn;
         FB_COMM:  fbRaw = src.commIn;
         FB_SUM:   fbRaw = aSum > 11'(`PPR_FULL_PCT) ? 10'(`PPR_FULL_PCT)
                                                     : aSum[9:0];
         FB_MAX:   fbRaw = aOneBig ? src.analogInOne : src.analogInTwo;
         FB_MIN:   fbRaw = aOneBig ? src.analogInTwo : src.analogInOne;
         default:  fbRaw = src.analogInOne;
      endcase
   end

   // Gain set choice: fixed, by input, or interpolated on error size.
   function automatic logic [15:0] mixGain(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic [1:0]  mode,
                                           input logic        sel,
                                           input logic [15:0] ae,
                                           input logic [15:0] d1,
                                           input logic [15:0] d2);
      logic signed [47:0] t;
      t = {32'h0, a};
      if (mode == 2'h1 && sel) begin
         t = {32'h0, b};
      end else if (mode == 2'h2 && ae >= d2) begin
         t = {32'h0, b};
      end else if (mode == 2'h2 && ae > d1) begin
         t = $signed({32'h0, b}) - $signed({32'h0, a});
         t = $signed({32'h0, a}) + t * $signed({32'h0, ae - d1})
             / $signed({32'h0, d2 - d1});
      end
      return t[15:0];
   endfunction

   wire logic [15:0] absErr16 = absErr[15:0];
   wire logic [1:0]  swMode = cfgFf[`PPR_IX_SWMODE][1:0];
   assign kpSel = mixGain(cfgFf[`PPR_IX_KP1], cfgFf[`PPR_IX_KP2], swMode,
                          gainSyncFf[1], absErr16, cfgFf[`PPR_IX_SWDEV1],
                          cfgFf[`PPR_IX_SWDEV2]);
   assign tiSel = mixGain(cfgFf[`PPR_IX_TI1], cfgFf[`PPR_IX_TI2], swMode,
                          gainSyncFf[1], absErr16, cfgFf[`PPR_IX_SWDEV1],
                          cfgFf[`PPR_IX_SWDEV2]);
   assign tdSel = mixGain(cfgFf[`PPR_IX_TD1], cfgFf[`PPR_IX_TD2], swMode,
                          gainSyncFf[1], absErr16, cfgFf[`PPR_IX_SWDEV1],
                          cfgFf[`PPR_IX_SWDEV2]);

   // Setpoint ramp.
   wire logic [15:0] rampT = cfgFf[`PPR_IX_RAMPT];
   wire logic signed [47:0] spGoal = {38'h0, spTarget} <<< FR;
   wire logic signed [47:0] rampStepRaw = (48'(`PPR_FULL_PCT) <<< FR)
      / ({32'h0, rampT} * 48'(`PPR_TICKS_PER_CS) + 48'h1);
   wire logic signed [47:0] rampStep = rampStepRaw == 0 ? 48'h1
                                                         : rampStepRaw;
   always_comb begin
      nxt_spAcc = spGoal;
      if (rampT != 16'h0) begin
         if (spAccFf + rampStep < spGoal) begin
            nxt_spAcc = spAccFf + rampStep;
         end else if (spAccFf - rampStep > spGoal) begin
            nxt_spAcc = spAccFf - rampStep;
         end
      end
   end

   // First order filters, coefficient one over tau in ticks plus one.
   wire logic signed [47:0] fbDen =
      {32'h0, cfgFf[`PPR_IX_FBFILT]} * 48'(`PPR_TICKS_PER_CS) + 48'h1;
   wire logic signed [47:0] outDen =
      {32'h0, cfgFf[`PPR_IX_OUTFILT]} * 48'(`PPR_TICKS_PER_CS) + 48'h1;
   assign nxt_fbAcc = fbAccFf
      + (($signed({38'h0, fbRaw} <<< FR) - fbAccFf) / fbDen);

   // Proportional, integral and derivative terms.
   wire logic signed [47:0] pTerm = $signed({32'h0, kpSel}) * err * fMax
      / 48'sd1000000;
   wire logic signed [47:0] tiTicks = ({32'h0, tiSel} == 0 ? 48'h1
      : {32'h0, tiSel}) * 48'(`PPR_TICKS_PER_CS) * 48'(`PPR_FULL_PCT);
   wire logic signed [47:0] iStep = ((err * fMax) <<< FR) / tiTicks;
   wire logic signed [47:0] iLim = fMax <<< FR;
   wire logic signed [47:0] iSum = iAccFf + iStep;
   assign nxt_iAcc = iSum > iLim ? iLim : (iSum < -iLim ? -iLim : iSum);
   wire logic signed [47:0] fbRate = fbNow - fbPrevFf;
   wire logic signed [47:0] dRaw = -(fbRate * $signed({32'h0, tdSel}) * fMax)
      / 48'sd1000000;
   wire logic signed [47:0] dDir = dirRev ? -dRaw : dRaw;
   wire logic signed [47:0] dLim = {32'h0, cfgFf[`PPR_IX_DCLAMP]} * fMax
      / 48'd10000;
   wire logic signed [47:0] dTerm = dDir > dLim ? dLim
      : (dDir < -dLim ? -dLim : dDir);
   assign nxt_pid = pTerm + (nxt_iAcc >>> FR) + dTerm;

   // Output limits, applied to the sum when the main source is added.
   wire logic revOk = cfgFf[`PPR_IX_REVCUT] != 16'h0
                      && !cfgFf[`PPR_IX_REVPROH][0];
   wire logic signed [47:0] loLim = revOk
      ? -{32'h0, cfgFf[`PPR_IX_REVCUT]}
      : {32'h0, cfgFf[`PPR_IX_LOWER]};
   wire logic signed [47:0] hiLim = {32'h0, cfgFf[`PPR_IX_UPPER]};
   wire logic signed [47:0] preLim = cfgFf[`PPR_IX_COMBINE][0]
      ? pidFf + {{31{mainFreq[16]}}, mainFreq}
      : pidFf;
   wire logic signed [47:0] limited = preLim > hiLim ? hiLim
      : (preLim < loLim ? loLim : preLim);
   assign nxt_outAcc = outAccFf
      + (((limited <<< FR) - outAccFf) / outDen);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         spAccFf  <= 48'h0;
         fbAccFf  <= 48'h0;
         fbPrevFf <= 48'h0;
         iAccFf   <= 48'h0;
         pidFf    <= 48'h0;
         outAccFf <= 48'h0;
      end else if (tick) begin
         spAccFf  <= nxt_spAcc;
         fbAccFf  <= nxt_fbAcc;
         fbPrevFf <= fbNow;
         outAccFf <= nxt_outAcc;
         if (!holdPid) begin
            iAccFf <= nxt_iAcc;
            pidFf  <= nxt_pid;
         end
      end
   end

   // Scaled displays and frequency command.
   wire logic signed [47:0] spDispW = spEff * {32'h0, cfgFf[`PPR_IX_DISPFS]}
      / 48'(`PPR_FULL_PCT);
   wire logic signed [47:0] fbDispW = fbNow * {32'h0, cfgFf[`PPR_IX_DISPFS]}
      / 48'(`PPR_FULL_PCT);
   wire logic signed [47:0] outNow = outAccFf >>> FR;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         freqCmd         <= 17'h0;
         setpointDisplay <= 16'h0;
         feedbackDisplay <= 16'h0;
      end else if (tickDlyFf) begin
         freqCmd         <= outNow[16:0];
         setpointDisplay <= spDispW[15:0];
         feedbackDisplay <= fbDispW[15:0];
      end
   end

endmodule
